/* hdl/amp_ctrl_pkg.sv */
// Package of constants for the amplifier control serial slave
package amp_ctrl_pkg;
   localparam logic [6:0] slave_addr        = 7'h6c;  // 1101100x
   localparam int         sub_addr_bits     = 7;
   localparam int         num_instr         = 2;
   localparam int         num_diag          = 4;
   localparam logic [7:0] instr_reset       = 8'h00;
   localparam logic [2:0] bit_count_last    = 3'h7;
   localparam logic [6:0] idx_instr_1       = 7'h00;
   localparam logic [6:0] idx_instr_2       = 7'h01;
   // Field positions inside the instruction and diagnostic bytes
   localparam int         ib1_diag_bit      = 6;
   localparam int         ib1_offs_a_bit    = 5;
   localparam int         ib1_offs_b_bit    = 2;
   localparam int         ib1_offs_c_bit    = 1;
   localparam int         ib2_on_bit        = 4;
   localparam int         ib2_diag_off_bit  = 2;
   localparam int         db_offset_bit     = 2;
   localparam int         db3_standby_bit   = 7;
   localparam int         db3_diag_bit      = 6;
endpackage

/* hdl/amp_ctrl_link_if.sv */
// Interface carrying filtered bus line levels between sampler and slave core
`timescale 1ns/1ps
interface amp_ctrl_link_if;
   logic scl;
   logic sda;
   modport source (output scl, output sda);
   modport sink   (input scl, input sda);
endinterface

/* hdl/line_sync.sv */
// Three-stage synchroniser with agreement filter for one bus line
`timescale 1ns/1ps
module line_sync (
   // Clock and reset
   input  wire logic ref_clk_in,
   input  wire logic rstn_in,
   // Raw pin and filtered level
   input  wire logic pin_in,
   output logic      level_out
);
   logic [2:0] stage;

   // Shift chain; idle bus level is high
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         stage <= 3'h7;
      end else begin
         stage <= {stage[1:0], pin_in};
      end
   end

   // Level changes only once stages two and three agree
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         level_out <= 1'b1;
      end else if (stage[1] == stage[2]) begin
         level_out <= stage[2];
      end
   end
endmodule // line_sync

/* hdl/amp_control_serial_slave.sv */
// Two-wire control slave: instruction bytes in, four diagnostic bytes out
// Notes on behaviour
// - Respond to address 1101100x; last bit zero writes, one reads.
// - Sub-address MSB 0: following byte goes only to the named byte.
// - Sub-address MSB 1: auto increment, each byte to next address.
// - Read data is driven only after the address acknowledge bit.
// - Read returns diagnostic bytes for channels one to four in order.
// - Read ended otherwise: data line held until a new start.
// - Byte two XXX1X0XX after byte one: on, 26dB, mute, diagnostics on if byte one D6 is set.
// - Byte one X0XXXXXX with byte two XXX0XXXX turns amplifier off.
// - Byte one XX1XX11X with byte two XXX1X0XX starts offset detection.
// - A read after offset detection enable stops that procedure.
// - Bit D2 of each diagnostic byte reports detected output offset.
// - Byte three D7 mirrors byte two D4; D6 mirrors byte one D6.
`timescale 1ns/1ps
module amp_control_serial_slave
(
   // Clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       rstn_in,
   // Bus pins; data line as input, output level, active-low enable
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oen_out,
   // Diagnostic inputs from the analog section, one byte per channel
   input  wire logic [7:0] diag_ch1_in,
   input  wire logic [7:0] diag_ch2_in,
   input  wire logic [7:0] diag_ch3_in,
   input  wire logic [7:0] diag_ch4_in,
   input  wire logic [3:0] offset_detect_in,
   // Instruction bytes and decoded controls
   output logic [7:0]      instruction_byte_1_out,
   output logic [7:0]      instruction_byte_2_out,
   output logic            amp_on_out,
   output logic            mute_out,
   output logic            diag_enable_out,
   output logic            offset_detect_run_out,
   output logic            busy_out
);
   import amp_ctrl_pkg::*;

   typedef enum {st_idle, st_addr, st_addr_ack, st_sub, st_sub_ack,
                 st_wdata, st_wdata_ack, st_rdata, st_rdata_ack} state_t;

   amp_ctrl_link_if link ();
   logic scl_f;
   logic sda_f;

   line_sync u_scl (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .pin_in(scl_in), .level_out(scl_f));
   line_sync u_sda (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .pin_in(sda_in), .level_out(sda_f));
   assign link.scl = scl_f;
   assign link.sda = sda_f;

   state_t     state;
   logic       scl_d;
   logic       sda_d;
   logic [2:0] bit_cnt;
   logic [7:0] shift_in;
   logic [7:0] shift_out;
   logic [6:0] sub_addr;
   logic       auto_inc;
   logic       read_dir;
   logic [1:0] diag_idx;
   logic [7:0] instr [num_instr];
   logic       next_ib1_written;
   logic       ib1_written;

   // Bus edge and condition detection on filtered levels
   wire scl_rise = link.scl && !scl_d;
   wire scl_fall = !link.scl && scl_d;
   wire start_c  = link.scl && scl_d && sda_d && !link.sda;
   wire stop_c   = link.scl && scl_d && !sda_d && link.sda;
   wire [7:0] byte_in = {shift_in[6:0], link.sda};

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= link.scl;
         sda_d <= link.sda;
      end
   end

   // Diagnostic byte assembly; offset bit and mirrored status bits
   function automatic logic [7:0] diag_byte(input logic [1:0] idx);
      logic [7:0] b;
      b = 8'h00;
      case (idx)
         2'h0: b = diag_ch1_in;
         2'h1: b = diag_ch2_in;
         2'h2: b = diag_ch3_in;
         default: b = diag_ch4_in;
      endcase
      b[db_offset_bit] = offset_detect_in[idx];
      if (idx == 2'h2) begin
         b[db3_standby_bit] = instr[1][ib2_on_bit];
         b[db3_diag_bit]    = instr[0][ib1_diag_bit];
      end
      return b;
   endfunction

   // Outgoing bytes; a call result cannot be bit-selected, so latch it in a variable
   logic [7:0] first_db;
   logic [7:0] next_db;
   always_comb begin
      first_db = diag_byte(2'h0);
      next_db  = diag_byte(diag_idx);
   end

   // Current data byte lands in instruction byte one
   assign next_ib1_written = (sub_addr == idx_instr_1);

   // Protocol state machine; sampled on clock rise, driven after clock fall
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state     <= st_idle;
         bit_cnt   <= 3'h0;
         shift_in  <= 8'h00;
         shift_out <= 8'h00;
         sub_addr  <= 7'h00;
         auto_inc  <= 1'b0;
         read_dir  <= 1'b0;
         diag_idx  <= 2'h0;
         sda_out   <= 1'b1;
         sda_oen_out <= 1'b1;
         instr[0]  <= instr_reset;
         instr[1]  <= instr_reset;
         ib1_written <= 1'b0;
      end else if (start_c) begin
         // A new start always frees the data line
         state       <= st_addr;
         bit_cnt     <= 3'h0;
         sda_oen_out <= 1'b1;
         ib1_written <= 1'b0;
      end else if (stop_c && state != st_rdata && state != st_rdata_ack) begin
         state       <= st_idle;
         sda_oen_out <= 1'b1;
      end else begin
         case (state)
            st_addr, st_sub, st_wdata: begin
               if (scl_rise) begin
                  shift_in <= byte_in;                     // MSB first
                  bit_cnt  <= bit_cnt + 3'h1;
                  if (bit_cnt == bit_count_last) begin
                     if (state == st_addr) begin
                        state    <= (byte_in[7:1] == slave_addr) ? st_addr_ack : st_idle;
                        read_dir <= byte_in[0];
                     end else if (state == st_sub) begin
                        auto_inc <= byte_in[7];
                        sub_addr <= byte_in[6:0];
                        state    <= st_sub_ack;
                     end else begin
                        if (sub_addr < 7'(num_instr)) begin
                           instr[sub_addr[0]] <= byte_in;
                        end
                        if (next_ib1_written) begin
                           ib1_written <= 1'b1;
                        end
                        state <= st_wdata_ack;
                     end
                  end
               end
            end
            st_addr_ack, st_sub_ack, st_wdata_ack: begin
               if (scl_fall && sda_oen_out) begin
                  sda_out     <= 1'b0;                     // Acknowledge
                  sda_oen_out <= 1'b0;
               end else if (scl_fall) begin
                  sda_oen_out <= 1'b1;
                  sda_out     <= 1'b1;
                  bit_cnt     <= 3'h0;
                  if (state == st_addr_ack && read_dir) begin
                     // Data goes out only after the address acknowledge
                     diag_idx    <= 2'h1;
                     shift_out   <= {first_db[6:0], 1'b0};
                     sda_out     <= first_db[7];
                     sda_oen_out <= 1'b0;
                     state       <= st_rdata;
                  end else if (state == st_addr_ack) begin
                     state <= st_sub;
                  end else if (state == st_sub_ack) begin
                     state <= st_wdata;
                  end else begin
                     // Single-address mode takes no further bytes
                     if (auto_inc) begin
                        sub_addr <= sub_addr + 7'h01;
                        state    <= st_wdata;
                     end else begin
                        state <= st_idle;
                     end
                  end
               end
            end
            st_rdata: begin
               if (scl_fall) begin
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == bit_count_last) begin
                     sda_oen_out <= 1'b1;                  // Release for master acknowledge
                     sda_out     <= 1'b1;
                     state       <= st_rdata_ack;
                  end else begin
                     sda_out   <= shift_out[7];
                     shift_out <= {shift_out[6:0], 1'b0};
                  end
               end
            end
            st_rdata_ack: begin
               if (scl_rise) begin
                  read_dir <= link.sda;                    // Remember ack or not-ack
               end else if (scl_fall) begin
                  bit_cnt <= 3'h0;
                  if (read_dir) begin
                     state <= st_idle;                     // Not-acknowledge ends read
                  end else begin
                     // Next channel in fixed order, wraps after four
                     sda_out     <= next_db[7];
                     shift_out   <= {next_db[6:0], 1'b0};
                     sda_oen_out <= 1'b0;                  // Held until a new start
                     diag_idx    <= diag_idx + 2'h1;
                     state       <= st_rdata;
                  end
               end
            end
            default: begin
               state       <= st_idle;
               sda_oen_out <= 1'b1;
            end
         endcase
      end
   end

   // Decoded amplifier controls from the instruction bytes
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         amp_on_out            <= 1'b0;
         mute_out              <= 1'b1;
         diag_enable_out       <= 1'b0;
         offset_detect_run_out <= 1'b0;
      end else if (state == st_addr_ack && read_dir && scl_fall && !sda_oen_out) begin
         offset_detect_run_out <= 1'b0;                    // Read stops offset detection
      end else if (stop_c && ib1_written) begin
         amp_on_out      <= instr[1][ib2_on_bit];
         diag_enable_out <= instr[0][ib1_diag_bit] && !instr[1][ib2_diag_off_bit];
         mute_out        <= 1'b1;                          // Turn-on always starts muted
         offset_detect_run_out <= instr[0][ib1_offs_a_bit] && instr[0][ib1_offs_b_bit]
                                  && instr[0][ib1_offs_c_bit] && instr[1][ib2_on_bit]
                                  && !instr[1][ib2_diag_off_bit];
      end
   end

   // Mirrors of stored instruction bytes and busy status
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         instruction_byte_1_out <= instr_reset;
         instruction_byte_2_out <= instr_reset;
         busy_out               <= 1'b0;
      end else begin
         instruction_byte_1_out <= instr[0];
         instruction_byte_2_out <= instr[1];
         busy_out               <= (state != st_idle);
      end
   end
endmodule // amp_control_serial_slave

/* sim/host_master_model.sv */
// Bus master model: drives the bus clock and pulls the data line low
`timescale 1ns/1ps
module host_master_model (
   // Clock and wired data line
   input  wire logic clk_in,
   input  wire logic sda_line_in,
   // Bus clock and data pull-down
   output logic      scl_out,
   output logic      sda_low_out
);
   int hp = 8;  // Half bus period in clocks; slave needs six
   // Bus idle: both lines released
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // One bit; data moves only while the bus clock is low
   task automatic bit_xfer(input logic b, output logic s);
      sda_low_out = !b;
      tick(hp / 2);
      scl_out = 1'b1;
      tick(hp / 2);
      s = sda_line_in;
      tick(hp / 2);
      scl_out = 1'b0;
      tick(hp / 2);
   endtask
   task automatic start();
      sda_low_out = 1'b0;
      tick(hp / 2);
      scl_out = 1'b1;
      tick(hp);
      sda_low_out = 1'b1;
      tick(hp);
      scl_out = 1'b0;
      tick(hp / 2);
   endtask
   // Stop, then at least one bus period idle before the next start
   task automatic stop();
      sda_low_out = 1'b1;
      tick(hp / 2);
      scl_out = 1'b1;
      tick(hp);
      sda_low_out = 1'b0;
      tick(2 * hp);
   endtask
   // Most significant bit first; released ninth bit carries the answer
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_xfer(d[i], s);
      bit_xfer(1'b1, s);
      ack = !s;
   endtask
   // Last byte of a proper read gets a not-acknowledge
   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(1'b1, s);
         d[i] = s;
      end
      bit_xfer(last, s);
   endtask
endmodule // host_master_model

/* sim/amp_ctrl_sva.sv */
// Port checker for the amplifier control slave
`timescale 1ns/1ps
module amp_ctrl_sva
   import amp_ctrl_pkg::*;
(
   // Clock, reset and bus pins
   input wire logic       ref_clk_in,
   input wire logic       rstn_in,
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oen_out,
   // Stored bytes and controls
   input wire logic [7:0] instruction_byte_1_out,
   input wire logic [7:0] instruction_byte_2_out,
   input wire logic       amp_on_out,
   input wire logic       mute_out,
   input wire logic       offset_detect_run_out,
   input wire logic       busy_out
);
   wire logic [7:0] ib1 = instruction_byte_1_out;
   wire logic [7:0] ib2 = instruction_byte_2_out;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   // Start: data falls while the bus clock is high
   sequence s_start;
      scl_in && $fell(sda_in);
   endsequence
   a_start_wakes_slave: assert property (s_start |-> ##[1:10] busy_out)
      else $error("slave not busy after start");
   a_idle_line_free: assert property (!busy_out && !$past(busy_out) |-> sda_oen_out)
      else $error("data line driven while idle");
   a_drive_clock_low: assert property ($fell(sda_oen_out) |-> !scl_in)
      else $error("drive began with bus clock high");
   a_data_stable_high: assert property (!sda_oen_out && $changed(sda_out) |-> !scl_in)
      else $error("driven data moved with bus clock high");
   a_turn_on_muted: assert property ($rose(amp_on_out) |-> mute_out && ib2[ib2_on_bit])
      else $error("turn on without mute or standby bit");
   a_turn_off_bits: assert property ($fell(amp_on_out) |-> !ib2[ib2_on_bit] && !ib1[ib1_diag_bit])
      else $error("turn off without both bits clear");
   a_offset_start_bits: assert property ($rose(offset_detect_run_out) |->
      ib1[5] && ib1[2] && ib1[1] && ib2[4] && !ib2[2])
      else $error("offset detection started by wrong bytes");
   a_update_at_stop: assert property ($changed(amp_on_out) |-> scl_in)
      else $error("control changed with bus clock low");
endmodule // amp_ctrl_sva
bind amp_control_serial_slave amp_ctrl_sva u_sva (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oen_out(sda_oen_out), .instruction_byte_1_out(instruction_byte_1_out),
   .instruction_byte_2_out(instruction_byte_2_out), .amp_on_out(amp_on_out), .mute_out(mute_out),
   .offset_detect_run_out(offset_detect_run_out), .busy_out(busy_out));

/* sim/testbench.sv */
// Self-checking bench for the amplifier control slave
`timescale 1ns/1ps
module testbench;
   import amp_ctrl_pkg::*;
   logic       clk, rstn, scl, m_low, sda_out, sda_oen, amp_on, mute, diag_en, off_run, busy;
   logic [7:0] ib1, ib2, acks;
   logic [7:0] d [4];
   // Analog-side inputs kept as variables so the readback can follow them
   logic [7:0] diag [4] = '{8'h81, 8'hc4, 8'h1b, 8'h7e};
   logic [3:0] offs = 4'h5;
   logic [7:0] exp_db [4] = '{8'h85, 8'hc0, 8'hdf, 8'h7a};
   int         num_errors = 0;
   int         cmp_count = 0;
   int         cyc = 0;
   wire  logic sda = !m_low && (sda_oen || sda_out);  // Wired-AND, pull-up
   amp_control_serial_slave dut (.ref_clk_in(clk), .rstn_in(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oen_out(sda_oen), .diag_ch1_in(diag[0]), .diag_ch2_in(diag[1]), .diag_ch3_in(diag[2]),
      .diag_ch4_in(diag[3]), .offset_detect_in(offs), .instruction_byte_1_out(ib1), .instruction_byte_2_out(ib2),
      .amp_on_out(amp_on),
      .mute_out(mute), .diag_enable_out(diag_en), .offset_detect_run_out(off_run), .busy_out(busy));
   host_master_model m (.clk_in(clk), .sda_line_in(sda), .scl_out(scl), .sda_low_out(m_low));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Tests need about 3600 clocks; a hang is cut at 40000
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         num_errors++;
         conclude();
      end
   end
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   // Whole write transfer of n bytes from the top of w; acks collects one bit per byte
   task automatic wr_seq(input int n, input logic [31:0] w);
      logic a;
      acks = 8'h00;
      m.start();
      for (int i = 0; i < n; i++) begin
         m.wr_byte(w[31 - 8 * i -: 8], a);
         acks[i] = a;
      end
      m.stop();
   endtask
   task automatic rd_seq(input int n, input logic nack_last);
      logic a;
      m.start();
      m.wr_byte({slave_addr, 1'b1}, a);
      chk("read address ack", 8'h01, {7'h0, a});
      for (int i = 0; i < n; i++)
         m.rd_byte(nack_last && i == n - 1, d[i]);
      m.stop();
   endtask
   // Offset flags 0101 replace bit 2; byte three bits 7..6 mirror stored bytes
   initial begin
      rstn = 1'b0;
      m.tick(16);
      rstn = 1'b1;
      chk("reset state", 8'h06, {4'h0, busy, sda_oen, mute, amp_on});
      m.tick(4);
      wr_seq(2, 32'hda800000);
      chk("foreign address acks", 8'h00, acks);
      chk("foreign address busy", 8'h00, {7'h0, busy});
      $display("test foreign address done");
      wr_seq(4, 32'hd8806610);
      chk("auto write acks", 8'h0f, acks);
      chk("byte one", 8'h66, ib1);
      chk("byte two", 8'h10, ib2);
      chk("controls on", 8'h0f, {4'h0, amp_on, mute, off_run, diag_en});
      $display("test offset enable done");
      rd_seq(4, 1'b1);
      foreach (d[i])
         chk("diag byte", exp_db[i], d[i]);
      chk("offset stopped", 8'h00, {7'h0, off_run});
      $display("test diagnostic read done");
      wr_seq(4, 32'hd8000055);
      chk("single write acks", 8'h07, acks);
      chk("single byte one", 8'h00, ib1);
      chk("single byte two", 8'h10, ib2);
      chk("single controls", 8'h0c, {4'h0, amp_on, mute, off_run, diag_en});
      $display("test single address done");
      wr_seq(4, 32'hd8800000);
      chk("off acks", 8'h0f, acks);
      chk("controls off", 8'h04, {4'h0, amp_on, mute, off_run, diag_en});
      $display("test turn off done");
      // Channel one bit 2 set on its input but masked by a clear offset flag
      diag[0] = 8'h04;
      offs = 4'h0;
      m.hp = 12;
      rd_seq(1, 1'b0);
      chk("aborted byte", 8'h00, d[0]);
      chk("held line", 8'h02, {6'h0, busy, sda_oen});
      m.start();
      m.stop();
      chk("line freed", 8'h01, {7'h0, sda_oen});
      $display("test aborted read done");
      conclude();
   end
endmodule // testbench
